// File: design/fieldbus_master_setup.sv
// start-up configuration core of the fieldbus master with wishbone registers
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ns
module fieldbus_master_setup #(
  parameter int CNT_HS_NARROW = fieldbus_setup_pkg::CYC_HS_NARROW,
  parameter int CNT_HS_WIDE = fieldbus_setup_pkg::CYC_HS_WIDE,
  parameter int CNT_LD_NARROW = fieldbus_setup_pkg::CYC_LD_NARROW,
  parameter int CNT_LD_WIDE = fieldbus_setup_pkg::CYC_LD_WIDE
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // selector and configuration pins
  input wire logic [3:0] unit_tens,
  input wire logic [3:0] unit_ones,
  input wire logic node_range,
  input wire logic link_rate_select,
  input wire logic stop_mode,
  input wire logic regs_enable,
  // link side events
  input wire logic link_err,
  input wire logic [15:0] slave_present,
  // link control outputs
  output logic exchange_en,
  output logic poll_tick,
  output logic bit_tick,
  output logic wide_range,
  output logic long_dist
);
  import fieldbus_setup_pkg::*;

  setup_link_if lnk ();

  setup_state_t state_r;
  logic [6:0] unit_r;
  logic wide_r;
  logic long_r;
  logic stopm_r;
  logic regs_r;
  logic overlap_r;
  logic range_err_r;
  logic halt_r;
  logic restart_req_r;
  logic [15:0] regtab_r;
  logic [15:0] joined_r;
  logic [15:0] illegal_r;
  logic [15:0] io_base_r;
  logic [15:0] param_base_r;
  logic [6:0] unit_bin;
  logic range_bad;
  logic wb_req;
  logic wb_wr;
  logic [6:0] peer_unit;
  logic peer_hit;
  logic [15:0] node_mask;
  logic [31:0] rd_data;

  // ==========================================
  // timer instance
  poll_timer #(
    .CNT_HS_NARROW(CNT_HS_NARROW),
    .CNT_HS_WIDE(CNT_HS_WIDE),
    .CNT_LD_NARROW(CNT_LD_NARROW),
    .CNT_LD_WIDE(CNT_LD_WIDE)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .lnk(lnk)
  );

  assign lnk.wide = wide_r;
  assign lnk.long_dist = long_r;
  assign lnk.run = (state_r == ST_RUN);

  // ==========================================
  // bus decode
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign peer_unit = wb_dat_i[6:0];

  // two decimal digits to binary
  assign unit_bin = 7'(unit_tens) * 7'h0a + 7'(unit_ones);

  // digits above nine or unit above the range limit block start
  assign range_bad = (unit_tens > DIGIT_MAX) || (unit_ones > DIGIT_MAX)
    || (unit_r > (wide_r ? UNIT_MAX_WIDE : UNIT_MAX_NARROW));

  // claimed units: own, plus next one in wide range
  assign peer_hit = wb_wr && (wb_adr_i == OFS_PEER) && wb_sel_i[0] && wb_sel_i[1]
    && wb_dat_i[PEER_VALID_BIT]
    && ((peer_unit == unit_r) || (wide_r && peer_unit == unit_r + 7'h01));

  assign node_mask = wide_r ? NODE_MASK_WIDE : NODE_MASK_NARROW;

  // ==========================================
  // start-up sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_SAMPLE;
    end else if (restart_req_r) begin
      state_r <= ST_SAMPLE;
    end else begin
      unique case (state_r)
        ST_SAMPLE: state_r <= ST_CHECK;
        ST_CHECK: begin
          if (!overlap_r && !range_bad) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (overlap_r || peer_hit) begin
            state_r <= ST_CHECK;
          end else if (link_err && stopm_r) begin
            state_r <= ST_HALT;
          end
        end
        ST_HALT: state_r <= ST_HALT;
      endcase
    end
  end

  // ==========================================
  // settings capture, only on reset release or restart
  always_ff @(posedge clk) begin
    if (rst) begin
      unit_r <= UNIT_RST;
      wide_r <= 1'b0;
      long_r <= 1'b0;
      stopm_r <= 1'b0;
      regs_r <= 1'b0;
    end else if (state_r == ST_SAMPLE) begin
      unit_r <= unit_bin;
      wide_r <= node_range;
      long_r <= link_rate_select;
      stopm_r <= stop_mode;
      regs_r <= regs_enable;
    end
  end

  // ==========================================
  // unit number range check
  always_ff @(posedge clk) begin
    if (rst) begin
      range_err_r <= 1'b0;
    end else if (state_r == ST_CHECK) begin
      range_err_r <= range_bad;
    end
  end

  // ==========================================
  // unit overlap flag, cleared only by restart
  always_ff @(posedge clk) begin
    if (rst) begin
      overlap_r <= 1'b0;
    end else if (peer_hit) begin
      overlap_r <= 1'b1;
    end else if (restart_req_r) begin
      overlap_r <= 1'b0;
    end
  end

  // ==========================================
  // halt flag for status
  always_ff @(posedge clk) begin
    if (rst) begin
      halt_r <= 1'b0;
    end else if (state_r == ST_RUN && link_err && stopm_r) begin
      halt_r <= 1'b1;
    end else if (restart_req_r) begin
      halt_r <= 1'b0;
    end
  end

  // ==========================================
  // restart command
  always_ff @(posedge clk) begin
    if (rst) begin
      restart_req_r <= 1'b0;
    end else begin
      restart_req_r <= wb_wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0]
        && wb_dat_i[CTRL_RESTART_BIT];
    end
  end

  // ==========================================
  // registration table
  always_ff @(posedge clk) begin
    if (rst) begin
      regtab_r <= 16'h0000;
    end else if (wb_wr && wb_adr_i == OFS_REGTAB) begin
      if (wb_sel_i[0]) begin
        regtab_r[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        regtab_r[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ==========================================
  // registration compare
  always_ff @(posedge clk) begin
    if (rst || restart_req_r) begin
      joined_r <= 16'h0000;
      illegal_r <= 16'h0000;
    end else if (regs_r && state_r == ST_RUN) begin
      joined_r <= regtab_r & slave_present & node_mask;
      illegal_r <= ~regtab_r & slave_present & node_mask;
    end else if (!regs_r) begin
      joined_r <= 16'h0000;
      illegal_r <= 16'h0000;
    end
  end

  // ==========================================
  // host window bases
  always_ff @(posedge clk) begin
    if (rst) begin
      io_base_r <= IO_BASE;
      param_base_r <= PARAM_BASE;
    end else begin
      io_base_r <= IO_BASE + 16'(IO_STEP * unit_r);
      param_base_r <= PARAM_BASE + 16'(PARAM_STEP * unit_r);
    end
  end

  // ==========================================
  // link outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      exchange_en <= 1'b0;
      poll_tick <= 1'b0;
      bit_tick <= 1'b0;
      wide_range <= 1'b0;
      long_dist <= 1'b0;
    end else begin
      exchange_en <= (state_r == ST_RUN) && !(link_err && stopm_r);
      poll_tick <= lnk.poll_tick;
      bit_tick <= lnk.bit_tick;
      wide_range <= wide_r;
      long_dist <= long_r;
    end
  end

  // ==========================================
  // read mux
  always_comb begin
    rd_data = 32'h00000000;
    unique case (wb_adr_i)
      OFS_STATUS: begin
        rd_data[ST_UNIT_LSB +: 7] = unit_r;
        rd_data[ST_WIDE_BIT] = wide_r;
        rd_data[ST_LONG_BIT] = long_r;
        rd_data[ST_STOPM_BIT] = stopm_r;
        rd_data[ST_REGS_BIT] = regs_r;
        rd_data[ST_RUN_BIT] = (state_r == ST_RUN);
        rd_data[ST_HALT_BIT] = halt_r;
        rd_data[ST_OVL_BIT] = overlap_r;
        rd_data[ST_RANGE_BIT] = range_err_r;
      end
      OFS_REGTAB: rd_data[15:0] = regtab_r;
      OFS_REGFLAG: rd_data = {illegal_r, joined_r};
      OFS_WINDOW: begin
        rd_data[15:0] = io_base_r;
        rd_data[23:16] = wide_r ? WORDS_WIDE : WORDS_NARROW;
        rd_data[31:24] = wide_r ? STAT_WIDE : STAT_NARROW;
      end
      OFS_PARAM: rd_data[15:0] = param_base_r;
      OFS_CYCLE: rd_data[16:0] = lnk.cycle_len;
      default: rd_data = 32'h00000000;
    endcase
  end

  // ==========================================
  // wishbone answer
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : 32'h00000000;
    end
  end
endmodule : fieldbus_master_setup

// File: design/fieldbus_setup_pkg.sv
// constants for the fieldbus master start-up configuration block
// Function
// - narrow range: nodes 0-7, ten-word window
// - wide range: nodes 0-15, twenty-word window
// - wide range claims own and next unit
// - unit number collision raises error, blocks start
// - unit number read as two decimal digits
// - unit number defaults to zero
// - all four configuration pins default off
// - link mode pin selects bit rate
// - poll cycle set by mode and range
// - slaves must share the master link mode
// - stop-mode pin halts exchange on link error
// - halted exchange resumes only after restart
// - registration pin enables slave registration checking
// - flag registered joined and unregistered illegal slaves
// - io window base 2000 plus ten per unit
// - parameter area base 20000 plus hundred per unit
package fieldbus_setup_pkg;
  // ==========================================
  // clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_HS_NARROW_US = 500;
  localparam int CYC_HS_WIDE_US = 800;
  localparam int CYC_LD_NARROW_US = 4000;
  localparam int CYC_LD_WIDE_US = 6000;
  localparam int CYC_HS_NARROW = CLK_HZ / 1_000_000 * CYC_HS_NARROW_US;
  localparam int CYC_HS_WIDE = CLK_HZ / 1_000_000 * CYC_HS_WIDE_US;
  localparam int CYC_LD_NARROW = CLK_HZ / 1_000_000 * CYC_LD_NARROW_US;
  localparam int CYC_LD_WIDE = CLK_HZ / 1_000_000 * CYC_LD_WIDE_US;
  localparam int BPS_HS = 750_000;
  localparam int BPS_LD_X100 = 9_375_000;
  localparam int BIT_DIV_HS = CLK_HZ / BPS_HS;
  localparam int BIT_DIV_LD = CLK_HZ / (BPS_LD_X100 / 100);
  // ==========================================
  // window allocation
  localparam logic [15:0] IO_BASE = 16'h07d0;
  localparam logic [15:0] IO_STEP = 16'h000a;
  localparam logic [15:0] PARAM_BASE = 16'h4e20;
  localparam logic [15:0] PARAM_STEP = 16'h0064;
  localparam logic [7:0] WORDS_NARROW = 8'h0a;
  localparam logic [7:0] WORDS_WIDE = 8'h14;
  localparam logic [7:0] STAT_NARROW = 8'h02;
  localparam logic [7:0] STAT_WIDE = 8'h04;
  localparam logic [15:0] NODE_MASK_NARROW = 16'h00ff;
  localparam logic [15:0] NODE_MASK_WIDE = 16'hffff;
  localparam logic [6:0] UNIT_MAX_NARROW = 7'h5f;
  localparam logic [6:0] UNIT_MAX_WIDE = 7'h5e;
  localparam logic [6:0] UNIT_RST = 7'h00;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  // ==========================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PEER = 8'h08;
  localparam logic [7:0] OFS_REGTAB = 8'h0c;
  localparam logic [7:0] OFS_REGFLAG = 8'h10;
  localparam logic [7:0] OFS_WINDOW = 8'h14;
  localparam logic [7:0] OFS_PARAM = 8'h18;
  localparam logic [7:0] OFS_CYCLE = 8'h1c;
  // ==========================================
  // status field positions
  localparam int ST_UNIT_LSB = 0;
  localparam int ST_WIDE_BIT = 8;
  localparam int ST_LONG_BIT = 9;
  localparam int ST_STOPM_BIT = 10;
  localparam int ST_REGS_BIT = 11;
  localparam int ST_RUN_BIT = 16;
  localparam int ST_HALT_BIT = 17;
  localparam int ST_OVL_BIT = 18;
  localparam int ST_RANGE_BIT = 19;
  localparam int CTRL_RESTART_BIT = 0;
  localparam int PEER_VALID_BIT = 8;
  typedef enum logic [1:0] {ST_SAMPLE, ST_CHECK, ST_RUN, ST_HALT} setup_state_t;
endpackage : fieldbus_setup_pkg

// File: design/poll_timer.sv
// polling cycle and bit rate timer
`timescale 1ns/1ns
module poll_timer #(
  parameter int CNT_HS_NARROW = 10000,
  parameter int CNT_HS_WIDE = 16000,
  parameter int CNT_LD_NARROW = 80000,
  parameter int CNT_LD_WIDE = 120000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration and ticks
  setup_link_if.timer lnk
);
  import fieldbus_setup_pkg::*;

  logic [16:0] cyc_cnt_r;
  logic [7:0] bit_cnt_r;
  logic [16:0] len;
  logic [7:0] bit_len;

  // ==========================================
  // period selection
  always_comb begin
    unique case ({lnk.long_dist, lnk.wide})
      2'b00: len = 17'(CNT_HS_NARROW);
      2'b01: len = 17'(CNT_HS_WIDE);
      2'b10: len = 17'(CNT_LD_NARROW);
      2'b11: len = 17'(CNT_LD_WIDE);
    endcase
    bit_len = lnk.long_dist ? 8'(BIT_DIV_LD) : 8'(BIT_DIV_HS);
  end

  assign lnk.cycle_len = len;

  // ==========================================
  // poll cycle counter
  always_ff @(posedge clk) begin
    if (rst || !lnk.run) begin
      cyc_cnt_r <= 17'h00000;
      lnk.poll_tick <= 1'b0;
    end else if (cyc_cnt_r == len - 17'h00001) begin
      cyc_cnt_r <= 17'h00000;
      lnk.poll_tick <= 1'b1;
    end else begin
      cyc_cnt_r <= cyc_cnt_r + 17'h00001;
      lnk.poll_tick <= 1'b0;
    end
  end

  // ==========================================
  // bit rate divider
  always_ff @(posedge clk) begin
    if (rst || !lnk.run) begin
      bit_cnt_r <= 8'h00;
      lnk.bit_tick <= 1'b0;
    end else if (bit_cnt_r == bit_len - 8'h01) begin
      bit_cnt_r <= 8'h00;
      lnk.bit_tick <= 1'b1;
    end else begin
      bit_cnt_r <= bit_cnt_r + 8'h01;
      lnk.bit_tick <= 1'b0;
    end
  end
endmodule : poll_timer

// File: design/setup_link_if.sv
// configuration and tick signals between setup core and poll timer
`timescale 1ns/1ns
interface setup_link_if;
  logic wide;
  logic long_dist;
  logic run;
  logic poll_tick;
  logic bit_tick;
  logic [16:0] cycle_len;
  modport core (output wide, output long_dist, output run, input poll_tick, input bit_tick,
    input cycle_len);
  modport timer (input wide, input long_dist, input run, output poll_tick, output bit_tick,
    output cycle_len);
endinterface : setup_link_if

// File: tb/setup_checker.sv
// port assertions for the fieldbus master setup block
`timescale 1ns/1ns
module setup_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins and link
  input wire logic node_range,
  input wire logic link_rate_select,
  input wire logic stop_mode,
  input wire logic link_err,
  input wire logic exchange_en,
  input wire logic poll_tick,
  input wire logic bit_tick,
  input wire logic wide_range,
  input wire logic long_dist
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // bus handshake
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_shot: assert property (s_req |=> s_ans)
    else $error("ack not a single cycle after request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  // ==========================================
  // link events and settings
  a_halt_on_err: assert property (exchange_en && link_err && stop_mode |=> !exchange_en)
    else $error("exchange kept after link error in stop mode");
  a_run_on_err: assert property (
    exchange_en && link_err && !stop_mode && !wb_cyc_i && !$past(wb_cyc_i) |=> exchange_en)
    else $error("exchange dropped in continue mode");
  a_cfg_at_start: assert property (
    $rose(exchange_en) |-> wide_range == node_range && long_dist == link_rate_select)
    else $error("settings outputs differ from pins at start");
  a_ticks_need_run: assert property (
    !exchange_en && !$past(exchange_en) && !$past(exchange_en, 2) |-> !poll_tick && !bit_tick)
    else $error("tick while exchange is off");
  a_poll_one_pulse: assert property (poll_tick |=> !poll_tick)
    else $error("poll tick longer than one cycle");
  a_bit_one_pulse: assert property (bit_tick |=> !bit_tick)
    else $error("bit tick longer than one cycle");
endmodule : setup_checker
bind fieldbus_master_setup setup_checker u_setup_checker (.clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .node_range, .link_rate_select, .stop_mode, .link_err, .exchange_en,
  .poll_tick, .bit_tick, .wide_range, .long_dist);

// File: tb/slave_model.sv
// remote slave terminals seen from the master
`timescale 1ns/1ns
module slave_model (
  // bench controls
  input wire logic [15:0] joined,
  input wire logic [15:0] slave_long,
  input wire logic err_inject,
  // master side
  input wire logic long_dist,
  output logic [15:0] slave_present,
  output logic link_err
);
  // a slave on the other link mode never shows up
  assign slave_present = joined & ~(slave_long ^ {16{long_dist}});
  assign link_err = err_inject;
endmodule : slave_model

// File: tb/testbench.sv
// self-checking bench for the fieldbus master setup block
`timescale 1ns/1ns
module testbench;
  import fieldbus_setup_pkg::*;
  localparam int CHN = 20, CHW = 32, CLN = 160, CLW = 240;
  typedef struct packed {
    logic [3:0] t; logic [3:0] o; logic nr; logic lr; logic sm; logic rg; logic ok;
    logic [15:0] io; logic [15:0] prm;
  } row_t;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, nr = 0, lr = 0, sm = 0, rg = 0, inj = 0;
  logic [3:0] tens = 4'h0, ones = 4'h0, sel = 4'hf;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [15:0] joined = 16'h0, slong = 16'h0, present;
  logic ack, lerr, xen, ptick, btick, wide, longd;
  logic [6:0] u;
  int errors = 0, compares = 0, cycles = 0, n, ce;
  row_t r;
  row_t rows [6] = '{
    '{4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h07d0, 16'h4e20},
    '{4'h9, 4'h5, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0b86, 16'h733c},
    '{4'h9, 4'h4, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0b7c, 16'h72d8},
    '{4'h3, 4'h7, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0942, 16'h5c94},
    '{4'h1, 4'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0848, 16'h52d0},
    '{4'h9, 4'h5, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0b86, 16'h733c}};
  always #25 clk = ~clk;
  fieldbus_master_setup #(.CNT_HS_NARROW(CHN), .CNT_HS_WIDE(CHW), .CNT_LD_NARROW(CLN),
    .CNT_LD_WIDE(CLW)) u_fieldbus_master_setup (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .unit_tens(tens), .unit_ones(ones), .node_range(nr),
    .link_rate_select(lr), .stop_mode(sm), .regs_enable(rg), .link_err(lerr),
    .slave_present(present), .exchange_en(xen), .poll_tick(ptick), .bit_tick(btick),
    .wide_range(wide), .long_dist(longd));
  slave_model u_slave_model (.joined(joined), .slave_long(slong), .err_inject(inj),
    .long_dist(longd), .slave_present(present), .link_err(lerr));
  // ==========================================
  // tasks
  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask : wb
  task automatic cfg(input logic [3:0] t, input logic [3:0] o, input logic [3:0] p);
    rst <= 1'b1;
    @(posedge clk);
    {tens, ones, nr, lr, sm, rg} <= {t, o, p};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : cfg
  task automatic period(input bit b, output int c);
    c = 1;
    while ((b ? btick : ptick) !== 1'b1) @(posedge clk);
    @(posedge clk);
    while ((b ? btick : ptick) !== 1'b1) begin
      c++;
      @(posedge clk);
    end
  endtask : period
  task automatic pulse_err;
    inj <= 1'b1;
    @(posedge clk);
    inj <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_err
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      summarize();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      cfg(r.t, r.o, {r.nr, r.lr, r.sm, r.rg});
      u = 7'(r.t) * 7'h0a + 7'(r.o);
      ce = r.lr ? (r.nr ? CLW : CLN) : (r.nr ? CHW : CHN);
      wb(1'b0, OFS_STATUS, 32'h0);
      chk("status", {12'h0, ~r.ok, 2'b0, r.ok, 4'h0, r.rg, r.sm, r.lr, r.nr, 1'b0, u}, rd);
      chk("exchange", 32'(r.ok), 32'(xen));
      if (r.ok) begin
        chk("wide", 32'(r.nr), 32'(wide));
        chk("long", 32'(r.lr), 32'(longd));
        wb(1'b0, OFS_WINDOW, 32'h0);
        chk("window", {r.nr ? STAT_WIDE : STAT_NARROW, r.nr ? WORDS_WIDE : WORDS_NARROW, r.io}, rd);
        wb(1'b0, OFS_PARAM, 32'h0);
        chk("param", {16'h0, r.prm}, rd);
        wb(1'b0, OFS_CYCLE, 32'h0);
        chk("cycle", 32'(ce), rd);
        period(1'b0, n);
        chk("poll_period", 32'(ce), 32'(n));
        period(1'b1, n);
        chk("bit_period", 32'(r.lr ? BIT_DIV_LD : BIT_DIV_HS), 32'(n));
      end
    end
    cfg(4'h1, 4'h2, 4'h0);
    pulse_err();
    chk("continue", 32'h1, 32'(xen));
    cfg(4'h1, 4'h2, 4'h2);
    pulse_err();
    repeat (20) @(posedge clk);
    chk("halted", 32'h0, 32'(xen));
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("halt_flag", 32'h1, 32'(rd[ST_HALT_BIT]));
    wb(1'b1, OFS_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    chk("restarted", 32'h1, 32'(xen));
    cfg(4'h1, 4'h2, 4'h8);
    wb(1'b1, OFS_PEER, 32'h0000_010e);
    repeat (2) @(posedge clk);
    chk("peer_clear", 32'h1, 32'(xen));
    wb(1'b1, OFS_PEER, 32'h0000_010d);
    repeat (2) @(posedge clk);
    chk("peer_hit", 32'h0, 32'(xen));
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("overlap", 32'h1, 32'(rd[ST_OVL_BIT]));
    cfg(4'h0, 4'hc, 4'h0);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("digit_range", 32'h0008_000c, rd);
    chk("digit_block", 32'h0, 32'(xen));
    cfg(4'h1, 4'h2, 4'h1);
    joined <= 16'h0203;
    wb(1'b1, OFS_REGTAB, 32'h0000_0005);
    wb(1'b0, OFS_REGTAB, 32'h0);
    chk("regtab", 32'h0000_0005, rd);
    wb(1'b0, OFS_REGFLAG, 32'h0);
    chk("regflag", 32'h0002_0001, rd);
    slong <= 16'h0001;
    repeat (2) @(posedge clk);
    wb(1'b0, OFS_REGFLAG, 32'h0);
    chk("mode_mismatch", 32'h0002_0000, rd);
    cfg(4'h1, 4'h2, 4'h0);
    wb(1'b0, OFS_REGFLAG, 32'h0);
    chk("regs_off", 32'h0, rd);
    {nr, tens} <= {1'b1, 4'h3};
    repeat (2) @(posedge clk);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("hold", 32'h0001_000c, rd);
    wb(1'b1, OFS_STATUS, 32'hffff_ffff);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("read_only", 32'h0001_000c, rd);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    sel <= 4'h1;
    wb(1'b1, OFS_REGTAB, 32'h0000_abcd);
    sel <= 4'hf;
    wb(1'b0, OFS_REGTAB, 32'h0);
    chk("regtab_sel", 32'h0000_00cd, rd);
    summarize();
  end
endmodule : testbench
